// ### hw/css_pkg.sv
// package for the shift, stack and return execution block
// assumes an 8-bit core with zero page at 0x00xx and stack page at 0x01xx
package css_pkg;

    // memory pages
    localparam logic [7:0]  ZP_PAGE    = 8'h00;
    localparam logic [7:0]  STACK_PAGE = 8'h01;

    // status register bit positions
    localparam int          PS_N       = 7;
    localparam int          PS_T       = 5;
    localparam int          PS_Z       = 1;
    localparam int          PS_C       = 0;

    // reset values
    localparam logic [7:0]  A_RST      = 8'h00;
    localparam logic [7:0]  S_RST      = 8'hFF;
    localparam logic [7:0]  PS_RST     = 8'h00;
    localparam logic [15:0] PC_RST     = 16'h0000;

    // opcodes
    localparam logic [7:0]  OP_NOP     = 8'hEA;
    localparam logic [7:0]  OP_OR_IMM  = 8'h09;
    localparam logic [7:0]  OP_OR_ZP   = 8'h05;
    localparam logic [7:0]  OP_LSR_A   = 8'h4A;
    localparam logic [7:0]  OP_LSR_ZP  = 8'h46;
    localparam logic [7:0]  OP_ROL_A   = 8'h2A;
    localparam logic [7:0]  OP_ROL_ZP  = 8'h26;
    localparam logic [7:0]  OP_ROR_A   = 8'h6A;
    localparam logic [7:0]  OP_ROR_ZP  = 8'h66;
    localparam logic [7:0]  OP_NIB_ZP  = 8'h82;
    localparam logic [7:0]  OP_PUSH_A  = 8'h48;
    localparam logic [7:0]  OP_PUSH_S  = 8'h08;
    localparam logic [7:0]  OP_PULL_A  = 8'h68;
    localparam logic [7:0]  OP_PULL_S  = 8'h28;
    localparam logic [7:0]  OP_RET_INT = 8'h40;
    localparam logic [7:0]  OP_RET_SUB = 8'h60;
    localparam logic [7:0]  OP_MUL_ZPX = 8'h62;

    // instruction lengths and nibble rotate distance
    localparam logic [1:0]  LEN_ONE    = 2'h1;
    localparam logic [1:0]  LEN_TWO    = 2'h2;
    localparam int          NIB_SHIFT  = 4;
    localparam logic [15:0] RET_ADJ    = 16'h0001;

    // pops per stack-reading instruction, minus one
    localparam logic [1:0]  POPS_PULL  = 2'h0;
    localparam logic [1:0]  POPS_RTS   = 2'h1;
    localparam logic [1:0]  POPS_RTI   = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LAT_M = 3'b001,
        ST_LAT_X = 3'b010,
        ST_EXEC  = 3'b011,
        ST_WR    = 3'b100,
        ST_POP   = 3'b101,
        ST_DONE  = 3'b110
    } css_state_t;

    typedef enum logic [2:0] {
        ALU_OR  = 3'b000,
        ALU_LSR = 3'b001,
        ALU_ROL = 3'b010,
        ALU_ROR = 3'b011,
        ALU_NIB = 3'b100,
        ALU_MUL = 3'b101
    } css_alu_t;

    typedef enum logic [3:0] {
        K_NOP    = 4'b0000,
        K_ALU_A  = 4'b0001,
        K_ALU_M  = 4'b0010,
        K_OR     = 4'b0011,
        K_PUSH_A = 4'b0100,
        K_PUSH_S = 4'b0101,
        K_PULL_A = 4'b0110,
        K_PULL_S = 4'b0111,
        K_RTI    = 4'b1000,
        K_RTS    = 4'b1001,
        K_MUL    = 4'b1010,
        K_BAD    = 4'b1011
    } css_kind_t;

endpackage

// ### hw/css_alu.sv
// combinational byte datapath: or, shifts, rotates, nibble swap, multiply
// assumes the caller selects operands and owns all flag storage
`timescale 1ns/1ps
module css_alu (
    input  wire css_pkg::css_alu_t op_i,
    input  wire logic [7:0]        a_i,
    input  wire logic [7:0]        b_i,
    input  wire logic              c_i,
    output logic [7:0]             res_o,
    output logic [7:0]             hi_o,
    output logic                   c_o
);

    logic [15:0] prod;

    // full product, only used by the multiply
    assign prod = {8'h00, a_i} * {8'h00, b_i};

    // result and carry per operation
    always_comb begin
        res_o = b_i;
        hi_o  = 8'h00;
        c_o   = c_i;
        case (op_i)
            css_pkg::ALU_OR: begin
                res_o = a_i | b_i;
            end
            css_pkg::ALU_LSR: begin
                res_o = {1'b0, b_i[7:1]}; // RULE1
                c_o   = b_i[0]; // RULE1
            end
            css_pkg::ALU_ROL: begin
                res_o = {b_i[6:0], c_i}; // RULE10
                c_o   = b_i[7]; // RULE10
            end
            css_pkg::ALU_ROR: begin
                res_o = {c_i, b_i[7:1]}; // RULE11
                c_o   = b_i[0]; // RULE11
            end
            css_pkg::ALU_NIB: begin
                res_o = {b_i[css_pkg::NIB_SHIFT-1:0], b_i[7:css_pkg::NIB_SHIFT]}; // RULE12
            end
            css_pkg::ALU_MUL: begin
                res_o = prod[7:0]; // RULE2
                hi_o  = prod[15:8]; // RULE2
            end
            default: begin
                res_o = b_i;
            end
        endcase
    end

endmodule

// ### hw/css_exec.sv
// execution unit for shifts, rotates, or, multiply, stack and return ops
// assumes a memory port whose read data is valid in the cycle MEM_RE_O is high
//
// Overview of operation
// [RULE1] shift right: bits move toward bit 0, bit 7 cleared, old bit 0 to carry
// [RULE2] multiply A by zero-page-X byte; high byte pushed, S decremented, low in A
// [RULE3] no-operation only advances the program counter by one
// [RULE4] T clear: A ored with memory operand, result into A
// [RULE5] T set: byte at X ored with operand, stored at X; A kept, flags updated
// [RULE6] push A: write A at stack pointer, then decrement stack pointer
// [RULE7] push status: write status at stack pointer, then decrement stack pointer
// [RULE8] pull A: increment stack pointer, then load A from that byte
// [RULE9] pull status: increment stack pointer, then load status from that byte
// [RULE10] rotate left: bits toward bit 7, old carry to bit 0, bit 7 to carry
// [RULE11] rotate right: bits toward bit 0, old carry to bit 7, bit 0 to carry
// [RULE12] nibble rotate swaps halves of a zero-page byte and writes it back
// [RULE13] return from interrupt pops status, then counter low, then counter high
// [RULE14] return from subroutine pops counter low then high, then adds one
// [RULE15] or, shifts, rotates, pull A set N from bit 7 and Z on zero
`timescale 1ns/1ps
module css_exec (
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    input  wire logic        START_I,
    input  wire logic [7:0]  OPCODE_I,
    input  wire logic [7:0]  OPERAND_I,
    input  wire logic [7:0]  X_I,
    input  wire logic [7:0]  MEM_RDATA_I,
    output logic             BUSY_O,
    output logic             DONE_O,
    output logic             ILLEGAL_O,
    output logic [15:0]      MEM_ADDR_O,
    output logic [7:0]       MEM_WDATA_O,
    output logic             MEM_WE_O,
    output logic             MEM_RE_O,
    output logic [7:0]       A_O,
    output logic [7:0]       S_O,
    output logic [7:0]       PS_O,
    output logic [15:0]      PC_O
);

    css_pkg::css_state_t state_q, state_d;
    css_pkg::css_kind_t  kind_q, dec_kind;
    css_pkg::css_alu_t   alu_q, dec_alu;
    logic [1:0]          len_q, dec_len;
    logic                dec_imm;
    logic                t_q;
    logic [7:0]          opnd_q, x_q;
    logic [1:0]          cnt_q;
    logic [7:0]          m_q, mx_q;
    logic [7:0]          a_q, s_q, ps_q;
    logic [15:0]         pc_q;
    logic [15:0]         addr_q;
    logic [7:0]          wdata_q;
    logic                we_q, re_q;
    logic [7:0]          alu_a, alu_b, alu_res, alu_hi;
    logic                alu_c;
    logic                pop_last, wants_wr, t_or;

    // status with negative and zero taken from a result
    function automatic logic [7:0] with_nz(input logic [7:0] ps, input logic [7:0] r);
        logic [7:0] v;
        v = ps;
        v[css_pkg::PS_N] = r[7];
        v[css_pkg::PS_Z] = (r == 8'h00);
        return v;
    endfunction

    // opcode decode: datapath operation, then instruction kind
    always_comb begin
        dec_alu  = css_pkg::ALU_OR;
        dec_kind = css_pkg::K_BAD;
        case (OPCODE_I)
            css_pkg::OP_LSR_A,
            css_pkg::OP_LSR_ZP:  dec_alu = css_pkg::ALU_LSR;
            css_pkg::OP_ROL_A,
            css_pkg::OP_ROL_ZP:  dec_alu = css_pkg::ALU_ROL;
            css_pkg::OP_ROR_A,
            css_pkg::OP_ROR_ZP:  dec_alu = css_pkg::ALU_ROR;
            css_pkg::OP_NIB_ZP:  dec_alu = css_pkg::ALU_NIB;
            css_pkg::OP_MUL_ZPX: dec_alu = css_pkg::ALU_MUL;
            default:             dec_alu = css_pkg::ALU_OR;
        endcase
        case (OPCODE_I)
            css_pkg::OP_NOP:     dec_kind = css_pkg::K_NOP;
            css_pkg::OP_OR_IMM,
            css_pkg::OP_OR_ZP:   dec_kind = css_pkg::K_OR;
            css_pkg::OP_LSR_A,
            css_pkg::OP_ROL_A,
            css_pkg::OP_ROR_A:   dec_kind = css_pkg::K_ALU_A;
            css_pkg::OP_LSR_ZP,
            css_pkg::OP_ROL_ZP,
            css_pkg::OP_ROR_ZP,
            css_pkg::OP_NIB_ZP:  dec_kind = css_pkg::K_ALU_M;
            css_pkg::OP_MUL_ZPX: dec_kind = css_pkg::K_MUL;
            css_pkg::OP_PUSH_A:  dec_kind = css_pkg::K_PUSH_A;
            css_pkg::OP_PUSH_S:  dec_kind = css_pkg::K_PUSH_S;
            css_pkg::OP_PULL_A:  dec_kind = css_pkg::K_PULL_A;
            css_pkg::OP_PULL_S:  dec_kind = css_pkg::K_PULL_S;
            css_pkg::OP_RET_INT: dec_kind = css_pkg::K_RTI;
            css_pkg::OP_RET_SUB: dec_kind = css_pkg::K_RTS;
            default:             dec_kind = css_pkg::K_BAD;
        endcase
    end
    // immediate form and two-byte instructions
    assign dec_imm  = (OPCODE_I == css_pkg::OP_OR_IMM);
    assign dec_len  = (dec_kind == css_pkg::K_OR || dec_kind == css_pkg::K_ALU_M ||
                       dec_kind == css_pkg::K_MUL) ? css_pkg::LEN_TWO : css_pkg::LEN_ONE;
    // shared conditions; pop count minus one per stack-reading kind
    assign t_or     = (kind_q == css_pkg::K_OR) && t_q;
    assign pop_last = (kind_q == css_pkg::K_RTI) ? (cnt_q == css_pkg::POPS_RTI) :
                      (kind_q == css_pkg::K_RTS) ? (cnt_q == css_pkg::POPS_RTS) :
                      (cnt_q == css_pkg::POPS_PULL);
    assign wants_wr = (kind_q == css_pkg::K_ALU_M) || t_or || (kind_q == css_pkg::K_MUL)
                      || (kind_q == css_pkg::K_PUSH_A) || (kind_q == css_pkg::K_PUSH_S);

    // operand selection: t-mode or uses the byte at X in place of A
    assign alu_a = t_or ? mx_q : a_q; // RULE5
    assign alu_b = (kind_q == css_pkg::K_ALU_A) ? a_q : m_q;

    css_alu u_alu (
        .op_i  (alu_q),
        .a_i   (alu_a),
        .b_i   (alu_b),
        .c_i   (ps_q[css_pkg::PS_C]),
        .res_o (alu_res),
        .hi_o  (alu_hi),
        .c_o   (alu_c)
    );

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            css_pkg::ST_IDLE: begin
                if (START_I) begin
                    case (dec_kind)
                        css_pkg::K_OR:
                            state_d = !dec_imm ? css_pkg::ST_LAT_M :
                                      ps_q[css_pkg::PS_T] ? css_pkg::ST_LAT_X : css_pkg::ST_EXEC;
                        css_pkg::K_ALU_M,
                        css_pkg::K_MUL:    state_d = css_pkg::ST_LAT_M;
                        css_pkg::K_PULL_A,
                        css_pkg::K_PULL_S,
                        css_pkg::K_RTI,
                        css_pkg::K_RTS:    state_d = css_pkg::ST_POP;
                        default:           state_d = css_pkg::ST_EXEC;
                    endcase
                end
            end
            css_pkg::ST_LAT_M: state_d = t_or ? css_pkg::ST_LAT_X : css_pkg::ST_EXEC;
            css_pkg::ST_LAT_X: state_d = css_pkg::ST_EXEC;
            css_pkg::ST_EXEC:  state_d = wants_wr ? css_pkg::ST_WR : css_pkg::ST_DONE;
            css_pkg::ST_WR:    state_d = css_pkg::ST_DONE;
            css_pkg::ST_POP:   state_d = pop_last ? css_pkg::ST_DONE : css_pkg::ST_POP;
            css_pkg::ST_DONE:  state_d = css_pkg::ST_IDLE;
            default:           state_d = css_pkg::ST_IDLE;
        endcase
    end

    // state and pop counter
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q <= css_pkg::ST_IDLE;
            cnt_q   <= 2'h0;
        end else begin
            state_q <= state_d;
            if (state_q == css_pkg::ST_POP) begin
                cnt_q <= cnt_q + 2'h1;
            end else begin
                cnt_q <= 2'h0;
            end
        end
    end

    // instruction latch, taken when a request is accepted
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            kind_q <= css_pkg::K_NOP;
            alu_q  <= css_pkg::ALU_OR;
            len_q  <= css_pkg::LEN_ONE;
            t_q    <= 1'b0;
            opnd_q <= 8'h00;
            x_q    <= 8'h00;
        end else if (state_q == css_pkg::ST_IDLE && START_I) begin
            kind_q <= dec_kind;
            alu_q  <= dec_alu;
            len_q  <= dec_len;
            t_q    <= ps_q[css_pkg::PS_T];
            opnd_q <= OPERAND_I;
            x_q    <= X_I;
        end
    end

    // operand bytes: memory operand and byte at X
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            m_q  <= 8'h00;
            mx_q <= 8'h00;
        end else begin
            if (state_q == css_pkg::ST_IDLE && START_I && dec_imm) begin
                m_q <= OPERAND_I;
            end else if (state_q == css_pkg::ST_LAT_M) begin
                m_q <= MEM_RDATA_I;
            end
            if (state_q == css_pkg::ST_LAT_X) begin
                mx_q <= MEM_RDATA_I;
            end
        end
    end

    // memory bus, registered; reads and writes issued on state entry
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            addr_q  <= 16'h0000;
            wdata_q <= 8'h00;
            we_q    <= 1'b0;
            re_q    <= 1'b0;
        end else begin
            we_q <= 1'b0;
            re_q <= 1'b0;
            case (state_q)
                css_pkg::ST_IDLE: begin
                    re_q <= START_I && (state_d != css_pkg::ST_EXEC);
                    case (state_d)
                        css_pkg::ST_LAT_M: addr_q <= (dec_kind == css_pkg::K_MUL) ?
                            {css_pkg::ZP_PAGE, OPERAND_I + X_I} : // RULE2
                            {css_pkg::ZP_PAGE, OPERAND_I};
                        css_pkg::ST_LAT_X: addr_q <= {css_pkg::ZP_PAGE, X_I}; // RULE5
                        css_pkg::ST_POP: addr_q <= {css_pkg::STACK_PAGE, s_q + 8'h01}; // RULE8
                        default:           addr_q <= addr_q;
                    endcase
                end
                css_pkg::ST_LAT_M: begin
                    if (t_or) begin
                        re_q   <= 1'b1;
                        addr_q <= {css_pkg::ZP_PAGE, x_q}; // RULE5
                    end
                end
                css_pkg::ST_EXEC: begin
                    we_q <= wants_wr;
                    case (kind_q)
                        css_pkg::K_ALU_M: addr_q <= {css_pkg::ZP_PAGE, opnd_q};
                        css_pkg::K_OR:    addr_q <= {css_pkg::ZP_PAGE, x_q}; // RULE5
                        default:          addr_q <= {css_pkg::STACK_PAGE, s_q}; // RULE2 RULE6 RULE7
                    endcase
                    case (kind_q)
                        css_pkg::K_PUSH_A: wdata_q <= a_q; // RULE6
                        css_pkg::K_PUSH_S: wdata_q <= ps_q; // RULE7
                        css_pkg::K_MUL:    wdata_q <= alu_hi; // RULE2
                        default:           wdata_q <= alu_res; // RULE1 RULE5 RULE10 RULE11 RULE12
                    endcase
                end
                css_pkg::ST_POP: begin
                    if (!pop_last) begin
                        re_q   <= 1'b1;
                        addr_q <= {css_pkg::STACK_PAGE, s_q + 8'h01}; // RULE13 RULE14
                    end
                end
                default: begin
                    addr_q <= addr_q;
                end
            endcase
        end
    end

    // stack pointer: pre-increment on each pop, decrement after each push
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s_q <= css_pkg::S_RST;
        end else if (state_d == css_pkg::ST_POP) begin
            s_q <= s_q + 8'h01; // RULE8 RULE9 RULE13 RULE14
        end else if (state_q == css_pkg::ST_WR && kind_q != css_pkg::K_ALU_M && !t_or) begin
            s_q <= s_q - 8'h01; // RULE2 RULE6 RULE7
        end
    end

    // accumulator and status
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            a_q  <= css_pkg::A_RST;
            ps_q <= css_pkg::PS_RST;
        end else if (state_q == css_pkg::ST_EXEC) begin
            case (kind_q)
                css_pkg::K_ALU_A: begin
                    a_q                  <= alu_res; // RULE1 RULE10 RULE11
                    ps_q                 <= with_nz(ps_q, alu_res); // RULE15
                    ps_q[css_pkg::PS_C]  <= alu_c; // RULE1 RULE10 RULE11
                end
                css_pkg::K_ALU_M: begin
                    if (alu_q != css_pkg::ALU_NIB) begin
                        ps_q                <= with_nz(ps_q, alu_res); // RULE15
                        ps_q[css_pkg::PS_C] <= alu_c;
                    end
                end
                css_pkg::K_OR: begin
                    if (!t_q) begin
                        a_q <= alu_res; // RULE4
                    end
                    ps_q <= with_nz(ps_q, alu_res); // RULE5 RULE15
                end
                css_pkg::K_MUL: a_q <= alu_res; // RULE2
                default:        a_q <= a_q; // RULE3
            endcase
        end else if (state_q == css_pkg::ST_POP) begin
            if (kind_q == css_pkg::K_PULL_A) begin
                a_q  <= MEM_RDATA_I; // RULE8
                ps_q <= with_nz(ps_q, MEM_RDATA_I); // RULE15
            end else if (kind_q == css_pkg::K_PULL_S ||
                         (kind_q == css_pkg::K_RTI && cnt_q == 2'h0)) begin
                ps_q <= MEM_RDATA_I; // RULE9 RULE13
            end
        end
    end

    // program counter
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pc_q <= css_pkg::PC_RST;
        end else if (state_q == css_pkg::ST_POP) begin
            if ((kind_q == css_pkg::K_RTS && cnt_q == 2'h0) ||
                (kind_q == css_pkg::K_RTI && cnt_q == 2'h1)) begin
                pc_q[7:0] <= MEM_RDATA_I; // RULE13 RULE14
            end else if (kind_q == css_pkg::K_RTS && cnt_q == 2'h1) begin
                pc_q <= {MEM_RDATA_I, pc_q[7:0]} + css_pkg::RET_ADJ; // RULE14
            end else if (kind_q == css_pkg::K_RTI && cnt_q == 2'h2) begin
                pc_q[15:8] <= MEM_RDATA_I; // RULE13
            end
        end else if (state_q == css_pkg::ST_DONE && kind_q != css_pkg::K_RTI &&
                     kind_q != css_pkg::K_RTS && kind_q != css_pkg::K_BAD) begin
            pc_q <= pc_q + {14'h0000, len_q}; // RULE3
        end
    end

    // outputs
    assign BUSY_O      = (state_q != css_pkg::ST_IDLE);
    assign DONE_O      = (state_q == css_pkg::ST_DONE);
    assign ILLEGAL_O   = (state_q == css_pkg::ST_DONE) && (kind_q == css_pkg::K_BAD);
    assign MEM_ADDR_O  = addr_q;
    assign MEM_WDATA_O = wdata_q;
    assign MEM_WE_O    = we_q;
    assign MEM_RE_O    = re_q;
    assign A_O         = a_q;
    assign S_O         = s_q;
    assign PS_O        = ps_q;
    assign PC_O        = pc_q;

endmodule

// ### tb/css_mem_model.sv
// byte memory model on the far side of the execution unit
// assumes at most one read or write strobe a cycle
`timescale 1ns/1ps
module css_mem_model (
    input  wire logic        clk_i,
    input  wire logic        re_i,
    input  wire logic        we_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic [7:0]       rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    // data only while strobed, inverse of last byte otherwise
    assign rdata_o = re_i ? mem[addr_i] : ~last_q;
    // writes land at the closing edge of the strobe cycle
    always @(posedge clk_i) begin
        if (we_i) mem[addr_i] <= wdata_i;
        if (re_i) last_q <= rdata_o;
    end
endmodule

// ### tb/css_exec_props.sv
// port checker for the execution unit
// assumes it is bound onto every css_exec instance
`timescale 1ns/1ps
module css_exec_props (
    input wire logic        REF_CLK_I,
    input wire logic        RST_I,
    input wire logic        START_I,
    input wire logic [7:0]  OPCODE_I,
    input wire logic [7:0]  MEM_RDATA_I,
    input wire logic        BUSY_O,
    input wire logic        DONE_O,
    input wire logic [15:0] MEM_ADDR_O,
    input wire logic [7:0]  MEM_WDATA_O,
    input wire logic        MEM_WE_O,
    input wire logic        MEM_RE_O,
    input wire logic [7:0]  A_O,
    input wire logic [7:0]  S_O,
    input wire logic [7:0]  PS_O,
    input wire logic [15:0] PC_O
);
    logic [7:0]  op_q;
    logic [15:0] rd_q;
    logic        c_q;
    wire         take = START_I && !BUSY_O;
    wire         stk  = MEM_ADDR_O[15:8] == css_pkg::STACK_PAGE;
    // opcode, carry and last two read bytes
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            op_q <= 8'h00;
            c_q  <= 1'b0;
            rd_q <= 16'h0000;
        end else begin
            if (take) op_q <= OPCODE_I;
            if (take) c_q <= PS_O[css_pkg::PS_C];
            if (MEM_RE_O) rd_q <= {rd_q[7:0], MEM_RDATA_I};
        end
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    push_dec_a: assert property (MEM_WE_O && stk |=> S_O == $past(MEM_ADDR_O[7:0]) - 8'h01)
        else $error("stack write without pointer decrement");
    pull_load_a: assert property (take && OPCODE_I == css_pkg::OP_PULL_A |-> ##3
        (A_O == rd_q[7:0] && S_O == $past(S_O, 3) + 8'h01)) else $error("pull result wrong");
    nop_keep_a: assert property (take && OPCODE_I == css_pkg::OP_NOP |-> ##3
        (PC_O == $past(PC_O, 3) + 16'h0001 && A_O == $past(A_O, 3) && PS_O == $past(PS_O, 3)))
        else $error("no-operation changed state");
    lsr_wr_a: assert property (MEM_WE_O && op_q == css_pkg::OP_LSR_ZP |->
        MEM_WDATA_O == {1'b0, rd_q[7:1]}) else $error("shift right write wrong");
    ror_wr_a: assert property (MEM_WE_O && op_q == css_pkg::OP_ROR_ZP |->
        MEM_WDATA_O == {c_q, rd_q[7:1]}) else $error("rotate right write wrong");
    nib_wr_a: assert property (MEM_WE_O && op_q == css_pkg::OP_NIB_ZP |->
        MEM_WDATA_O == {rd_q[3:0], rd_q[7:4]}) else $error("nibble rotate write wrong");
    rts_pc_a: assert property (DONE_O && op_q == css_pkg::OP_RET_SUB |=>
        PC_O == {rd_q[7:0], rd_q[15:8]} + 16'h0001) else $error("subroutine return pc wrong");
    rti_pc_a: assert property (DONE_O && op_q == css_pkg::OP_RET_INT |=>
        PC_O == {rd_q[7:0], rd_q[15:8]}) else $error("interrupt return pc wrong");
    cover property (take && OPCODE_I == css_pkg::OP_MUL_ZPX);
    cover property (DONE_O && op_q == css_pkg::OP_RET_INT);
    cover property (MEM_WE_O && stk);
endmodule
bind css_exec css_exec_props u_props (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .START_I(START_I),
    .OPCODE_I(OPCODE_I), .MEM_RDATA_I(MEM_RDATA_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
    .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O), .MEM_WE_O(MEM_WE_O),
    .MEM_RE_O(MEM_RE_O), .A_O(A_O), .S_O(S_O), .PS_O(PS_O), .PC_O(PC_O));

// ### tb/testbench.sv
// self-checking bench for the execution unit
// assumes the memory model and checker are compiled before it
`timescale 1ns/1ps
module testbench;
    logic        REF_CLK_I, RST_I, START_I, BUSY_O, DONE_O, ILLEGAL_O, MEM_WE_O, MEM_RE_O, ill;
    logic [7:0]  OPCODE_I, OPERAND_I, X_I, MEM_RDATA_I, MEM_WDATA_O, A_O, S_O, PS_O;
    logic [15:0] MEM_ADDR_O, PC_O;
    int          errors, n_tests;
    localparam logic [23:0] PRE [11] = '{24'h001002, 24'h002001, 24'h002202, 24'h0021A5,
        24'h001510, 24'h010012, 24'h010120, 24'h010278, 24'h010356, 24'h00300C, 24'h003103};
    css_exec dut (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .START_I(START_I), .OPCODE_I(OPCODE_I),
        .OPERAND_I(OPERAND_I), .X_I(X_I), .MEM_RDATA_I(MEM_RDATA_I), .BUSY_O(BUSY_O),
        .DONE_O(DONE_O), .ILLEGAL_O(ILLEGAL_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O),
        .MEM_WE_O(MEM_WE_O), .MEM_RE_O(MEM_RE_O), .A_O(A_O), .S_O(S_O), .PS_O(PS_O), .PC_O(PC_O));
    css_mem_model u_mem (.clk_i(REF_CLK_I), .re_i(MEM_RE_O), .we_i(MEM_WE_O), .addr_i(MEM_ADDR_O),
        .wdata_i(MEM_WDATA_O), .rdata_o(MEM_RDATA_I));
    // 100 ns clock
    initial begin
        REF_CLK_I = 1'b0;
        forever #50 REF_CLK_I = ~REF_CLK_I;
    end
    // counts and verdict
    task automatic wrap_up();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // compare one pair of values
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one instruction, bounded wait for done, settle one cycle
    task automatic run(input logic [7:0] op, input logic [7:0] opd, input logic [7:0] x);
        @(posedge REF_CLK_I);
        START_I <= 1'b1;
        OPCODE_I <= op;
        OPERAND_I <= opd;
        X_I <= x;
        @(posedge REF_CLK_I);
        START_I <= 1'b0;
        for (int k = 0; k < 20 && DONE_O !== 1'b1; k++) @(negedge REF_CLK_I);
        ill = ILLEGAL_O;
        if (DONE_O !== 1'b1) begin
            errors++;
            wrap_up();
        end else begin
            @(negedge REF_CLK_I);
        end
    endtask
    // or, shifts, rotates and nibble swap
    task automatic t_alu();
        run(css_pkg::OP_OR_IMM, 8'h81, 8'h00); chk({A_O, PS_O}, 16'h8180);
        run(css_pkg::OP_OR_ZP, 8'h10, 8'h00); chk({A_O, PS_O}, 16'h8380);
        run(css_pkg::OP_LSR_A, 8'h00, 8'h00); chk({A_O, PS_O}, 16'h4101);
        run(css_pkg::OP_ROL_A, 8'h00, 8'h00); chk({A_O, PS_O}, 16'h8380);
        run(css_pkg::OP_ROR_A, 8'h00, 8'h00); chk({A_O, PS_O}, 16'h4101);
        run(css_pkg::OP_LSR_ZP, 8'h20, 8'h00); chk({u_mem.mem[16'h0020], PS_O}, 16'h0003);
        run(css_pkg::OP_ROR_ZP, 8'h22, 8'h00); chk({u_mem.mem[16'h0022], PS_O}, 16'h8180);
        run(css_pkg::OP_NIB_ZP, 8'h21, 8'h00); chk({u_mem.mem[16'h0021], PS_O}, 16'h5A80);
    endtask
    // pushes, pulls and multiply onto the stack
    task automatic t_stack();
        run(css_pkg::OP_PUSH_A, 8'h00, 8'h00); chk({u_mem.mem[16'h01FF], S_O}, 16'h41FE);
        run(css_pkg::OP_PUSH_S, 8'h00, 8'h00); chk({u_mem.mem[16'h01FE], S_O}, 16'h80FD);
        run(css_pkg::OP_PULL_A, 8'h00, 8'h00); chk({A_O, S_O}, 16'h80FE);
        run(css_pkg::OP_PULL_S, 8'h00, 8'h00); chk({PS_O, S_O}, 16'h41FF);
        run(css_pkg::OP_OR_IMM, 8'h21, 8'h00); chk({A_O, PS_O}, 16'hA1C1);
        run(css_pkg::OP_MUL_ZPX, 8'h10, 8'h05); chk({A_O, S_O}, 16'h10FE);
        chk({u_mem.mem[16'h01FF], PS_O}, 16'h0AC1);
    endtask
    // returns with stack wrap, or with the T flag set, no-op, unknown opcode
    task automatic t_flow();
        run(css_pkg::OP_RET_SUB, 8'h00, 8'h00); chk(PC_O, 16'h120B);
        run(css_pkg::OP_RET_INT, 8'h00, 8'h00); chk(PC_O, 16'h5678);
        chk({PS_O, S_O}, 16'h2003);
        run(css_pkg::OP_OR_ZP, 8'h31, 8'h30); chk({u_mem.mem[16'h0030], A_O}, 16'h0F10);
        run(css_pkg::OP_NOP, 8'h00, 8'h00); chk(PC_O, 16'h567B);
        chk({A_O, PS_O}, 16'h1020);
        run(8'hFF, 8'h00, 8'h00);
        chk({7'h00, ill, PC_O[7:0]}, 16'h017B);
    endtask
    // reset, preload, scenarios, verdict
    initial begin
        errors = 0;
        n_tests = 0;
        RST_I = 1'b1;
        START_I = 1'b0;
        OPCODE_I = 8'h00;
        OPERAND_I = 8'h00;
        X_I = 8'h00;
        foreach (PRE[i]) u_mem.mem[PRE[i][23:8]] = PRE[i][7:0];
        repeat (10) @(posedge REF_CLK_I);
        RST_I <= 1'b0;
        @(negedge REF_CLK_I);
        chk({A_O, S_O}, 16'h00FF);
        chk(PC_O, 16'h0000);
        chk({PS_O, 5'h00, DONE_O, BUSY_O, MEM_WE_O}, 16'h0000);
        t_alu();
        t_stack();
        t_flow();
        wrap_up();
    end
endmodule
